// File: src/sppl_loader.sv
/*
  serial prom program loader: programming loop with read-back echo and
  an endless memory dump, on a byte-stream serial port and a prom port.
  assumes an outside uart presents received bytes with valid/ready and
  accepts bytes to send with valid/ready; the prom answers reads in one
  cycle.
*/
// How it works
// [RULE_01] on entering the programming routine one ready byte FF is sent.
// [RULE_02] the host sends two data bytes before awaiting the first echo.
// [RULE_03] the host answers each echo with the next data byte.
// [RULE_04] each received byte is written at the destination pointer.
// [RULE_05] the pointer starts at D000 by default and increments per byte.
// [RULE_06] after the delay the location is read back and echoed.
// [RULE_07] the next byte is held in the receiver until the next pass.
// [RULE_08] the loop never ends by itself; only reset stops it.
// [RULE_09] count, start address and program time have user overrides.
// [RULE_10] both index pointers are preset to defaults before the jump; the code has one pointer, ptr_y, and presets it to D000 along with prog_cyc.
// [RULE_11] the programming routine is entered at address BF00.
// [RULE_12] the dump starts at the caller's index and current baud.
// [RULE_13] the dump sends bytes from rising addresses until reset.
// [RULE_14] mode inputs are sampled only while reset is held.
// [RULE_15] bootstrap is entered by reset with both mode inputs low.
// [RULE_16] the host compares each echo with the byte it sent.
`timescale 1ns/1ps
`include "sppl_cfg.svh"
module sppl_loader
  import sppl_pkg::*;
#(
  parameter int ADDR_W = 16,
  parameter int PROG_CYC = `SPPL_DEF_PROG_CYC
)(
  input wire logic mclk,
  input wire logic srst,
  input wire logic mode_select_a,
  input wire logic mode_select_b,
  input wire logic jump_valid,
  input wire logic [ADDR_W-1:0] jump_addr,
  input wire logic dump_start,
  input wire logic [ADDR_W-1:0] user_dest,
  input wire logic [15:0] user_count,
  input wire logic [31:0] user_prog_cyc,
  input wire logic user_override,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  output logic rx_ready,
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic prom_wr,
  output logic prom_rd,
  output logic [ADDR_W-1:0] prom_addr,
  output logic [7:0] prom_wdata,
  input wire logic [7:0] prom_rdata,
  output logic boot_mode,
  output logic active
);
  // ************************************************
  // elaboration checks
  // ************************************************
  // entry point and default pointer need at least 16 address bits
  if (ADDR_W < 16) begin : g_addr_narrow
    $error("sppl_loader: address width below 16 bits");
  end
  // override and timer paths carry no more than 32 bits
  if (ADDR_W > 32) begin : g_addr_wide
    $error("sppl_loader: address width above 32 bits");
  end
  // a zero delay would read the cell back before it is written
  if (PROG_CYC < 1) begin : g_prog_short
    $error("sppl_loader: programming time below one cycle");
  end

  // ************************************************
  // state
  // ************************************************
  typedef struct packed {
    sppl_state_type st;
    logic [1:0] mode;
    logic [ADDR_W-1:0] ptr_y;
    logic [15:0] count;
    logic [31:0] prog_cyc;
    logic [7:0] echo;
    logic [7:0] tx_data;
    logic tx_valid;
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic start;
  } sppl_state_reg_type;
  sppl_state_reg_type s_r;
  sppl_state_reg_type s_nxt;
  logic rx_take;

  // ************************************************
  // programming delay
  // ************************************************
  sppl_mem_if mem ();

  sppl_prog_timer i_sppl_prog_timer (
    .mclk(mclk),
    .srst(srst),
    .mem(mem)
  );

  // a byte is taken only in the wait loop with the timer free
  assign rx_take = rx_valid && rx_ready;

  // ************************************************
  // next state
  // ************************************************
  always_comb begin
    s_nxt = s_r;
    s_nxt.wr = 1'b0;
    s_nxt.rd = 1'b0;
    s_nxt.start = 1'b0;
    // a byte on the line is gone once the far side takes it
    if (s_r.tx_valid && tx_ready) begin
      s_nxt.tx_valid = 1'b0;
    end
    case (s_r.st)
      SPPL_IDLE: begin
        // timing and address index preset before any jump
        s_nxt.ptr_y = ADDR_W'(`SPPL_DEF_DEST); // RULE_10
        s_nxt.prog_cyc = 32'(PROG_CYC); // RULE_10
        s_nxt.count = `SPPL_DEF_COUNT;
        if (user_override) begin
          s_nxt.ptr_y = user_dest; // RULE_09
          s_nxt.count = user_count; // RULE_09
          s_nxt.prog_cyc = user_prog_cyc; // RULE_09
        end
        if (s_r.mode == `SPPL_MODE_BOOT) begin // RULE_15
          if (jump_valid &&
              jump_addr == ADDR_W'(`SPPL_PROG_ENTRY)) begin // RULE_11
            s_nxt.st = SPPL_READY;
          end else if (dump_start) begin
            s_nxt.ptr_y = user_dest; // RULE_12
            s_nxt.st = SPPL_DUMP_RD;
          end
        end
      end

      SPPL_READY: begin
        if (!s_r.tx_valid) begin
          s_nxt.tx_data = `SPPL_READY_CHAR; // RULE_01
          s_nxt.tx_valid = 1'b1;
          s_nxt.st = SPPL_WAIT;
        end
      end

      SPPL_WAIT: begin
        // second host byte sits in the receiver while we program
        if (rx_take) begin // RULE_07
          s_nxt.wr = 1'b1; // RULE_04
          s_nxt.addr = s_r.ptr_y; // RULE_04
          s_nxt.wdata = rx_data; // RULE_04
          s_nxt.start = 1'b1;
          s_nxt.st = SPPL_PROG;
        end
      end

      SPPL_PROG: begin
        // the cell is read only after the whole delay
        if (mem.done) begin
          s_nxt.rd = 1'b1; // RULE_06
          s_nxt.st = SPPL_READ;
        end
      end

      SPPL_READ: begin
        // read data stands only while prom_rd is high: keep it
        s_nxt.echo = prom_rdata; // RULE_06
        s_nxt.st = SPPL_ECHO;
      end

      SPPL_ECHO: begin
        if (!s_r.tx_valid) begin
          s_nxt.tx_data = s_r.echo; // RULE_06
          s_nxt.tx_valid = 1'b1;
          s_nxt.ptr_y = s_r.ptr_y + ADDR_W'(1); // RULE_05
          if (s_r.count != 16'h0) begin
            s_nxt.count = s_r.count - 16'h1;
          end
          // count is informative only: loop runs until reset
          s_nxt.st = SPPL_WAIT; // RULE_08
        end
      end

      SPPL_DUMP_RD: begin
        // one byte on the line at a time; baud is the uart's own
        if (!s_r.tx_valid) begin // RULE_12
          s_nxt.rd = 1'b1;
          s_nxt.addr = s_r.ptr_y; // RULE_13
          s_nxt.st = SPPL_DUMP_TX;
        end
      end

      SPPL_DUMP_TX: begin
        // prom_rd is high in this cycle, so the data stands now
        s_nxt.tx_data = prom_rdata; // RULE_13
        s_nxt.tx_valid = 1'b1;
        s_nxt.ptr_y = s_r.ptr_y + ADDR_W'(1); // RULE_13
        s_nxt.st = SPPL_DUMP_RD; // RULE_13
      end

      default: begin
        s_nxt.st = SPPL_IDLE;
      end
    endcase
  end

  // ************************************************
  // registers
  // ************************************************
  always_ff @(posedge mclk) begin
    if (srst) begin
      s_r <= '0;
      // mode pins matter only while reset is held
      s_r.mode <= {mode_select_b, mode_select_a}; // RULE_14
    end else begin
      s_r <= s_nxt;
    end
  end

  // ************************************************
  // outputs
  // ************************************************
  assign mem.start = s_r.start;
  assign mem.cycles = s_r.prog_cyc;
  // the next byte waits in the receiver until the timer is free
  assign rx_ready = (s_r.st == SPPL_WAIT) && !mem.busy; // RULE_07
  assign tx_data = s_r.tx_data;
  assign tx_valid = s_r.tx_valid;
  assign prom_wr = s_r.wr;
  assign prom_rd = s_r.rd;
  assign prom_addr = s_r.addr;
  assign prom_wdata = s_r.wdata;
  assign boot_mode = (s_r.mode == `SPPL_MODE_BOOT);
  assign active = (s_r.st != SPPL_IDLE);
endmodule // sppl_loader

// File: src/sppl_cfg.svh
/*
  constants for the serial prom program loader: entry point, default
  pointer and count, ready character and timing counts.
  assumes inclusion by bare name from the loader module only.
*/
`ifndef SPPL_CFG_SVH
`define SPPL_CFG_SVH
`define SPPL_READY_CHAR    8'hFF
`define SPPL_PROG_ENTRY    16'hBF00
`define SPPL_DEF_DEST      16'hD000
`define SPPL_DEF_COUNT     16'h0800
`define SPPL_PROG_TIME_US  2
`define SPPL_CLK_MHZ       250
`define SPPL_DEF_PROG_CYC  (`SPPL_PROG_TIME_US * `SPPL_CLK_MHZ)
`define SPPL_MODE_BOOT     2'h0
`endif

// File: src/sppl_pkg.sv
/*
  types for the serial prom program loader.
  assumes sppl_cfg.svh is on the include path.
*/
package sppl_pkg;
  typedef enum logic [2:0] {
    SPPL_IDLE,
    SPPL_READY,
    SPPL_WAIT,
    SPPL_PROG,
    SPPL_READ,
    SPPL_ECHO,
    SPPL_DUMP_RD,
    SPPL_DUMP_TX
  } sppl_state_type;
endpackage

// File: src/sppl_mem_if.sv
/*
  memory port bundle between the loader sequencer and the prom timer.
  assumes one clock domain.
*/
`timescale 1ns/1ps
interface sppl_mem_if;
  logic start;
  logic [31:0] cycles;
  logic busy;
  logic done;
  modport seq (output start, output cycles, input busy, input done);
  modport tmr (input start, input cycles, output busy, output done);
endinterface

// File: src/sppl_prog_timer.sv
/*
  per-byte programming delay counter.
  assumes start pulses only while not busy.
*/
`timescale 1ns/1ps
module sppl_prog_timer
  import sppl_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  sppl_mem_if.tmr mem
);
  typedef struct packed {
    logic busy;
    logic done;
    logic [31:0] cnt;
  } sppl_tmr_type;
  sppl_tmr_type s_r;
  sppl_tmr_type s_nxt;
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    if (mem.start && !s_r.busy) begin
      s_nxt.busy = 1'b1;
      s_nxt.cnt = (mem.cycles == 32'h0) ? 32'h1 : mem.cycles;
    end else if (s_r.busy) begin
      s_nxt.cnt = s_r.cnt - 32'h1;
      if (s_r.cnt == 32'h1) begin
        s_nxt.busy = 1'b0;
        s_nxt.done = 1'b1;
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (srst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign mem.busy = s_r.busy;
  assign mem.done = s_r.done;
endmodule // sppl_prog_timer

// File: sim/sppl_loader_monitor.sv
/* port checker for the loader.
   assumes one clock and a synchronous reset. */
`timescale 1ns/1ps
module sppl_loader_monitor
  import sppl_pkg::*;
#(parameter int PROG_CYC = 5)(
  input wire logic mclk,
  input wire logic srst,
  input wire logic jump_valid,
  input wire logic [15:0] jump_addr,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic prom_wr,
  input wire logic prom_rd,
  input wire logic [7:0] prom_wdata,
  input wire logic boot_mode,
  input wire logic active
);
  // ****
  // checks
  // ****
  localparam int MAXW = PROG_CYC + 12;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  sequence s_jump;
    jump_valid && jump_addr == 16'hBF00 && boot_mode && !active;
  endsequence
  sequence s_take;
    rx_valid && rx_ready;
  endsequence
  property p_ready; s_jump |-> ##2 tx_valid && tx_data == 8'hFF; endproperty
  a_ready: assert property (p_ready) else $error("no ready");
  property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
  endproperty
  a_hold: assert property (p_hold) else $error("tx dropped");
  property p_wr; s_take |=> prom_wr && prom_wdata == $past(rx_data);
  endproperty
  a_wr: assert property (p_wr) else $error("no write");
  property p_delay; prom_wr |=> (!prom_rd) [*4] ##[1:MAXW] prom_rd;
  endproperty
  a_delay: assert property (p_delay) else $error("bad delay");
  property p_echo; $fell(prom_rd) |-> ##[0:2] tx_valid; endproperty
  a_echo: assert property (p_echo) else $error("no echo");
  property p_rxwait; prom_wr |-> (!rx_ready) [*6]; endproperty
  a_rxwait: assert property (p_rxwait) else $error("rx early");
  property p_mode; !srst |=> $stable(boot_mode); endproperty
  a_mode: assert property (p_mode) else $error("mode moved");
  property p_loop; active |=> active; endproperty
  a_loop: assert property (p_loop) else $error("loop ended");
endmodule // sppl_loader_monitor
bind sppl_loader sppl_loader_monitor #(.PROG_CYC(PROG_CYC))
  i_sppl_loader_monitor (.*);

// File: sim/sppl_host_model.sv
/* host model: sends bytes one ahead of the echo, checks each echo.
   assumes loader byte ports with valid/ready. */
`timescale 1ns/1ps
module sppl_host_model (
  input wire logic mclk,
  input wire logic srst,
  input wire logic slow,
  input wire logic [7:0] n_bytes,
  input wire logic [7:0] base,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  output int sent,
  output int echoed,
  output int bad
);
  // ****
  // host
  // ****
  logic seen_r;
  logic [1:0] ph_r;
  assign tx_ready = !slow || ph_r == 2'h3;
  assign rx_valid = seen_r && sent < n_bytes && sent <= echoed + 1;
  // idle line shows the inverse so a stale byte cannot pass
  assign rx_data = rx_valid ? base + 8'(sent) : ~(base + 8'(sent));
  always @(posedge mclk) begin
    if (srst) begin
      ph_r <= 2'h0;
      seen_r <= 1'b0;
      sent <= 0;
      echoed <= 0;
      bad <= 0;
    end else begin
      ph_r <= ph_r + 2'h1;
      if (rx_valid && rx_ready)
        sent <= sent + 1;
      if (tx_valid && tx_ready && !seen_r) begin
        seen_r <= 1'b1;
        bad <= bad + int'(tx_data !== 8'hFF);
      end
      if (tx_valid && tx_ready && seen_r) begin
        echoed <= echoed + 1;
        bad <= bad + int'(tx_data !== base + 8'(echoed));
      end
    end
  end
endmodule // sppl_host_model

// File: sim/sppl_loader_test.sv
/* loader bench: program, refuse, dump.
   assumes a combinational prom model here. */
`timescale 1ns/1ps
module sppl_loader_test;
  // ****
  // bench
  // ****
  logic mclk = 0, srst = 1, ma = 0, mb = 0, jv = 0, ds = 0, ov = 0;
  logic slow = 0;
  bit hung = 1'b0;
  logic [15:0] ja = 16'hBF00, ud = 16'h0000, pa;
  logic [7:0] rxd, txd, pwd, prd, base = 8'h00, nb = 8'h00;
  logic rxv, rxr, txv, txr, pw, pr, bm, act;
  logic [7:0] mem [0:65535];
  int sent, echoed, bad, k, got, miscompares = 0, checks_done = 0;
  always #2 mclk = ~mclk;
  always @(posedge mclk) if (pw) mem[pa] <= pwd;
  assign prd = pr ? mem[pa] : ~mem[pa];
  sppl_loader #(.PROG_CYC(5)) i_sppl_loader (.mclk(mclk), .srst(srst),
    .mode_select_a(ma), .mode_select_b(mb), .jump_valid(jv),
    .jump_addr(ja), .dump_start(ds), .user_dest(ud), .user_count(16'h0003),
    .user_prog_cyc(32'h0000_0009), .user_override(ov), .rx_data(rxd),
    .rx_valid(rxv), .rx_ready(rxr), .tx_data(txd), .tx_valid(txv),
    .tx_ready(txr), .prom_wr(pw), .prom_rd(pr), .prom_addr(pa),
    .prom_wdata(pwd), .prom_rdata(prd), .boot_mode(bm), .active(act));
  sppl_host_model i_sppl_host_model (.mclk(mclk), .srst(srst), .slow(slow),
    .n_bytes(nb), .base(base), .tx_data(txd), .tx_valid(txv),
    .tx_ready(txr), .rx_data(rxd), .rx_valid(rxv), .rx_ready(rxr),
    .sent(sent), .echoed(echoed), .bad(bad));
  task automatic chk(input logic ok, input string m);
    checks_done++;
    if (!ok) begin
      miscompares++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // pins move at release; the captured mode must not follow
  task automatic boot(input logic [1:0] m);
    @(posedge mclk);
    srst <= 1'b1;
    ma <= m[0];
    mb <= m[1];
    repeat (16) @(posedge mclk);
    srst <= 1'b0;
    ma <= ~m[0];
    mb <= ~m[1];
    @(posedge mclk);
  endtask
  task automatic prog(input logic s, input logic o, input logic [15:0] d,
                      input logic [7:0] e, input logic [7:0] n);
    @(posedge mclk);
    slow <= s;
    ov <= o;
    ud <= o ? d : 16'h4444;
    base <= e;
    nb <= n;
    boot(2'b00);
    jv <= 1'b1;
    @(posedge mclk);
    jv <= 1'b0;
    for (k = 0; k < 3000 && echoed < n; k++) @(negedge mclk);
    hung = (k >= 3000);
    chk(!hung, "echo timeout");
    chk(bad === 0, "echo");
    for (k = 0; k < n; k++) chk(mem[d + 16'(k)] === e + 8'(k), "prom");
    repeat (20) @(negedge mclk);
    chk(act === 1'b1 && rxr === 1'b1, "loop");
    $display("test prog done");
  endtask
  task automatic refuse(input logic [1:0] m, input logic [15:0] j);
    boot(m);
    ja <= j;
    jv <= 1'b1;
    ds <= (m != 2'b00);
    for (k = 0; k < 30 && txv !== 1'b1 && pr !== 1'b1; k++) @(negedge mclk);
    chk(k == 30 && bm === (m == 2'b00), "not ignored");
    @(posedge mclk);
    jv <= 1'b0;
    ds <= 1'b0;
    ja <= 16'hBF00;
    $display("test refuse done");
  endtask
  task automatic dump(input logic [15:0] d, input logic [7:0] e);
    @(posedge mclk);
    ov <= 1'b1;
    ud <= d;
    slow <= 1'b1;
    boot(2'b00);
    ds <= 1'b1;
    got = 0;
    for (k = 0; k < 400 && got < 3; k++) begin
      @(negedge mclk);
      if (txv === 1'b1 && txr === 1'b1) begin
        chk(txd === e + 8'(got), "dump");
        got++;
      end
    end
    hung = (got < 3);
    chk(!hung, "dump stall");
    $display("test dump done");
  endtask
  initial begin
    prog(1'b0, 1'b0, 16'hD000, 8'h30, 8'h06);
    if (!hung) prog(1'b1, 1'b1, 16'h1234, 8'hC1, 8'h03);
    if (!hung) refuse(2'b01, 16'hBF00);
    if (!hung) refuse(2'b10, 16'hBF00);
    if (!hung) refuse(2'b00, 16'hBF01);
    if (!hung) dump(16'hD002, 8'h32);
    stop_test();
  end
endmodule // sppl_loader_test
